/* File: hdl/asc_ctrl.sv */
/*
 Host controller for an asynchronous 512K x 8 static memory.
 A user request port starts single-byte reads and writes; the block drives
 select, write strobe, output drive, address and the two-way data bus.
 Assumes the memory sits on the pins with no clock and that the board
 resolves the data wire from the output enable.

 Write walk, counted from the edge that takes the request:
   one cycle of address and select with the strobe still high,
   then the strobe low for WR_CNT cycles with the host on the data wire,
   the strobe rising alone to end the write, and one more cycle in which
   data, address and select stay put before select is released.
 Ending on the strobe keeps the data hold measured from one known edge;
 select moves a cycle later, so it never ends the write itself.

 Read walk: select, output drive and address fall together and stand
 for RD_CNT cycles. The window covers the access time rounded up to whole
 clocks, the three synchroniser stages and the agreement stage behind them,
 so the byte taken is one that stood still on the pins for several edges.
 A cycle of float time follows before the next request can be taken,
 which keeps the host off the wire while the device lets go of it.

 Retention is granted only from idle, deselected, with the power-down
 time run out; a pending request is held off while it is asked for.
 A user who lowers the supply must wait for retention_ok first.
*/
// Operation
// - Write happens during select and strobe overlap
// - Releasing select or strobe ends write
// - Data timing measured from terminating edge
// - Data valid 25 ns before, 0 after end
// - Address stable 35 ns before write end
// - Address valid from write start to end
// - Strobe pulse covers setup plus 18 ns float
// - Host never drives bus while device drives
// - Strobe stays high during every read
// - Select high before retention entry
`timescale 1ns/1ps
module asc_ctrl (
	input  wire logic                       sys_clk,
	input  wire logic                       rstn,
	input  wire logic                       req_valid,
	input  wire logic                       req_write,
	input  wire logic [asc_pkg::ADDR_W-1:0] req_addr,
	input  wire logic [asc_pkg::DATA_W-1:0] req_wdata,
	input  wire logic                       retention_req,
	output logic                            req_ready,
	output logic                            rsp_valid,
	output logic      [asc_pkg::DATA_W-1:0] rsp_rdata,
	output logic                            retention_ok,
	output logic                            mem_select_n,
	output logic                            mem_write_n,
	output logic                            mem_drive_n,
	output logic      [asc_pkg::ADDR_W-1:0] mem_addr,
	output logic      [asc_pkg::DATA_W-1:0] mem_data_out,
	output logic                            mem_data_oe,
	input  wire logic [asc_pkg::DATA_W-1:0] mem_data_in
);
	import asc_pkg::*;

	typedef struct packed {
		asc_state_t        state;
		logic [CNT_W-1:0]  cnt;
		logic [CNT_W-1:0]  pd_cnt;
		logic              ready;
		logic              rsp;
		logic [DATA_W-1:0] rdata;
		logic              ret_ok;
		logic              sel_n;
		logic              we_n;
		logic              oe_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dout;
		logic              doe;
	} asc_ctrl_t;

	// Registered state and its next value
	asc_ctrl_t st_reg;
	asc_ctrl_t st_next;
	logic [DATA_W-1:0] din_sync;

	// Data pins come from outside the clock domain
	asc_sync asc_sync_inst (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.pin_in   (mem_data_in),
		.sync_out (din_sync)
	);

	// True on the last count of a timed phase
	function automatic logic cnt_last(input logic [CNT_W-1:0] c);
		return c == CNT_W'(1);
	endfunction : cnt_last

	// Sequencer for pin timing
	always_comb begin
		st_next     = st_reg;
		st_next.rsp = 1'b0;
		// Power-down timer runs while deselected
		if (st_reg.sel_n && st_reg.pd_cnt != '0) begin
			st_next.pd_cnt = st_reg.pd_cnt - 1'b1;
		end
		// Retention is granted only from a quiet idle
		st_next.ret_ok = retention_req && st_reg.sel_n
			&& st_reg.pd_cnt == '0 && st_reg.state == ASC_IDLE;

		unique case (st_reg.state)
			// Wait for a request; retention holds new ones off
			ASC_IDLE: begin
				st_next.ready = !retention_req;
				if (req_valid && st_reg.ready && !retention_req) begin
					st_next.ready = 1'b0;
					st_next.addr  = req_addr;
					st_next.sel_n = 1'b0;
					st_next.we_n  = 1'b1;
					if (req_write) begin
						// Address settles one cycle before strobe falls
						st_next.dout  = req_wdata;
						st_next.oe_n  = 1'b1;
						st_next.state = ASC_WSET;
					end else begin
						// Select, drive and address fall together
						st_next.oe_n  = 1'b0;
						st_next.cnt   = RD_CNT;
						st_next.state = ASC_RACC;
					end
				end
			end

			// Start the strobe pulse
			ASC_WSET: begin
				// Strobe falls with select low; bus driven only now
				st_next.we_n  = 1'b0;
				st_next.doe   = 1'b1;
				st_next.cnt   = WR_CNT;
				st_next.state = ASC_WPULS;
			end

			// Hold the strobe low for the pulse count
			ASC_WPULS: begin
				st_next.cnt = st_reg.cnt - 1'b1;
				if (cnt_last(st_reg.cnt)) begin
					// Strobe alone ends the write; select still low
					st_next.we_n  = 1'b1;
					st_next.state = ASC_WEND;
				end
			end

			// One cycle of hold, then release select and the wire
			ASC_WEND: begin
				// Data and address held one cycle past the ending edge
				st_next.doe    = 1'b0;
				st_next.sel_n  = 1'b1;
				st_next.pd_cnt = PD_CNT;
				st_next.ready  = !retention_req;
				st_next.state  = ASC_IDLE;
			end

			// Keep the device selected until its byte has crossed the synchroniser
			ASC_RACC: begin
				st_next.cnt = st_reg.cnt - 1'b1;
				if (cnt_last(st_reg.cnt)) begin
					// Take the settled byte and deselect on the same edge
					st_next.rdata  = din_sync;
					st_next.rsp    = 1'b1;
					st_next.oe_n   = 1'b1;
					st_next.sel_n  = 1'b1;
					st_next.pd_cnt = PD_CNT;
					st_next.cnt    = FLOAT_CNT;
					st_next.state  = ASC_RFLT;
				end
			end

			// Float time after a read
			ASC_RFLT: begin
				// Let the device float before anyone drives again
				st_next.cnt = st_reg.cnt - 1'b1;
				if (cnt_last(st_reg.cnt)) begin
					// Ready returns only once the wire is free
					st_next.ready = !retention_req;
					st_next.state = ASC_IDLE;
				end
			end

			// Unused codes fall back to idle
			default: begin
				st_next.state = ASC_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg       <= '0;
			st_reg.state <= ASC_IDLE;
			st_reg.sel_n <= 1'b1;
			st_reg.we_n  <= 1'b1;
			st_reg.oe_n  <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign req_ready    = st_reg.ready;
	assign rsp_valid    = st_reg.rsp;
	assign rsp_rdata    = st_reg.rdata;
	assign retention_ok = st_reg.ret_ok;
	assign mem_select_n = st_reg.sel_n;
	assign mem_write_n  = st_reg.we_n;
	assign mem_drive_n  = st_reg.oe_n;
	assign mem_addr     = st_reg.addr;
	assign mem_data_out = st_reg.dout;
	assign mem_data_oe  = st_reg.doe;
endmodule : asc_ctrl

/* File: hdl/asc_pkg.sv */
/*
 Package for the asynchronous static memory host controller.
 Holds pin widths, timing figures in ns and the cycle counts derived from sys_clk.
 Assumes a 40 MHz system clock.
*/
package asc_pkg;
	localparam int ADDR_W = 19;                      // Word address width
	localparam int DATA_W = 8;                       // Byte-wide data bus
	localparam int CLK_PERIOD_NS = 25;               // sys_clk period
	// Timing figures as specified, in ns
	localparam int CYCLE_TIME_NS               = 45; // Least spacing of accesses
	localparam int ADDRESS_ACCESS_TIME_NS      = 45; // Address to data valid, max
	localparam int CE_ACCESS_TIME_NS           = 45; // Select to data valid, max
	localparam int OUTPUT_DRIVE_ACCESS_TIME_NS = 22; // Output drive to data valid, max
	localparam int WRITE_DATA_SETUP_TIME_NS    = 25; // Data setup to write end
	localparam int ADDR_SETUP_WRITE_END_NS     = 35; // Address setup to write end
	localparam int STROBE_FLOAT_NS             = 18; // Strobe low to device float
	localparam int FLOAT_TIME_NS               = 18; // Select or drive high to float
	localparam int DESELECT_TO_RETENTION_TIME_NS = 0;
	localparam int POWER_DOWN_TIME_NS          = 45; // Deselect to power-down, max
	// Least times round up, waits for maximum delays round up too
	localparam int SYNC_N = 3;                        // Stages on the data input pins
	// Read window: access time in whole clocks, then the synchroniser stages and their agreement
	localparam int ACCESS_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_CYC = ACCESS_CYC + SYNC_N + 1;
	localparam int WR_PULSE_NS = (WRITE_DATA_SETUP_TIME_NS + STROBE_FLOAT_NS
		> ADDR_SETUP_WRITE_END_NS) ? WRITE_DATA_SETUP_TIME_NS + STROBE_FLOAT_NS
		: ADDR_SETUP_WRITE_END_NS;
	localparam int WR_CYC = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLOAT_CYC = (FLOAT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PD_CYC = (POWER_DOWN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 3;
	localparam logic [CNT_W-1:0] RD_CNT    = CNT_W'(RD_CYC);
	localparam logic [CNT_W-1:0] WR_CNT    = CNT_W'(WR_CYC);
	localparam logic [CNT_W-1:0] FLOAT_CNT = CNT_W'(FLOAT_CYC);
	localparam logic [CNT_W-1:0] PD_CNT    = CNT_W'(PD_CYC);
	typedef enum logic [2:0] {
		ASC_IDLE  = 3'b000,
		ASC_WSET  = 3'b001,
		ASC_WPULS = 3'b010,
		ASC_WEND  = 3'b011,
		ASC_RACC  = 3'b100,
		ASC_RFLT  = 3'b101
	} asc_state_t;
endpackage : asc_pkg

/* File: hdl/asc_sync.sv */
/*
 Input synchroniser for the data pins: three stages and an output flip-flop per bit.
 A bit counts as changed once the second and third stages agree.
 Assumes the pins are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module asc_sync (
	input  wire logic                       sys_clk,
	input  wire logic                       rstn,
	input  wire logic [asc_pkg::DATA_W-1:0] pin_in,
	output logic      [asc_pkg::DATA_W-1:0] sync_out
);
	import asc_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] s1;
		logic [DATA_W-1:0] s2;
		logic [DATA_W-1:0] s3;
		logic [DATA_W-1:0] q;
	} asc_sync_t;

	asc_sync_t st_reg;
	asc_sync_t st_next;

	// Shift the stages; take a bit only where stages two and three agree
	always_comb begin
		st_next    = st_reg;
		st_next.s1 = pin_in;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < DATA_W; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.q[i] = st_reg.s3[i];
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_out = st_reg.q;
endmodule : asc_sync

/* File: tb/asc_ctrl_asserts.sv */
/*
 Pin assertions for the memory host controller.
 Bound to asc_ctrl; sees its ports only.
*/
`timescale 1ns/1ps
module asc_ctrl_asserts (
	input wire logic                       sys_clk,
	input wire logic                       rstn,
	input wire logic                       req_valid,
	input wire logic                       req_write,
	input wire logic                       req_ready,
	input wire logic                       retention_req,
	input wire logic                       retention_ok,
	input wire logic                       rsp_valid,
	input wire logic                       mem_select_n,
	input wire logic                       mem_write_n,
	input wire logic                       mem_drive_n,
	input wire logic                       mem_data_oe,
	input wire logic [asc_pkg::ADDR_W-1:0] req_addr,
	input wire logic [asc_pkg::ADDR_W-1:0] mem_addr,
	input wire logic [asc_pkg::DATA_W-1:0] mem_data_out
);
	import asc_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Control pin combinations
	AST_RD_STROBE: assert property (!mem_select_n && !mem_drive_n |-> mem_write_n)
		else $error("strobe low in read");
	AST_NO_FIGHT: assert property (!mem_drive_n |-> !mem_data_oe)
		else $error("bus driven by both");
	AST_WR_OVERLAP: assert property (!mem_write_n |-> !mem_select_n && mem_data_oe && mem_drive_n)
		else $error("strobe without select");
	// Write timing around the strobe
	AST_WR_PULSE: assert property ($fell(mem_write_n) |-> !mem_write_n[*2] ##1 mem_write_n)
		else $error("strobe width");
	AST_WR_SETUP: assert property ($rose(mem_write_n) |-> mem_data_oe &&
		$past(mem_data_out, 2) == mem_data_out && $past(mem_addr, 3) == mem_addr)
		else $error("write setup");
	AST_WR_END: assert property ($rose(mem_write_n) |=> mem_select_n && !mem_data_oe)
		else $error("write end");
	AST_WR_START: assert property ($fell(mem_write_n) |-> $stable(mem_addr) && !$fell(mem_select_n))
		else $error("address late");
	// Read walk, spacing and retention
	AST_RD_WALK: assert property (req_valid && req_ready && !req_write && !retention_req |=>
		!mem_select_n && !mem_drive_n && mem_addr == $past(req_addr) ##6 rsp_valid)
		else $error("read walk");
	AST_SPACING: assert property ($fell(mem_select_n) |-> !mem_select_n[*3])
		else $error("access too short");
	AST_RETAIN: assert property (retention_ok |-> mem_select_n && !mem_data_oe && $past(retention_req))
		else $error("retention while selected");
endmodule : asc_ctrl_asserts

bind asc_ctrl asc_ctrl_asserts asc_ctrl_asserts_inst (.sys_clk, .rstn, .req_valid, .req_write,
	.req_ready, .retention_req, .retention_ok, .rsp_valid, .mem_select_n, .mem_write_n,
	.mem_drive_n, .mem_data_oe, .req_addr, .mem_addr, .mem_data_out);

/* File: tb/asc_ctrl_tb_top.sv */
/*
 Self-checking bench for the memory host controller.
 Drives the request port; the device model answers on the pins.
*/
`timescale 1ns/1ps
module asc_ctrl_tb_top;
	import asc_pkg::*;
	logic              sys_clk = 0, rstn = 0, req_valid = 0, req_write = 0, retention_req = 0;
	logic [ADDR_W-1:0] req_addr = '0, mem_addr;
	logic [DATA_W-1:0] req_wdata = '0, mem_data_out, rsp_rdata, dev_data, bus;
	logic              req_ready, rsp_valid, retention_ok, mem_select_n, mem_write_n;
	logic              mem_drive_n, mem_data_oe, dev_oe;
	int                mismatches = 0, n_checks = 0;
	// Data wire: host while its enable is high, else the device side
	assign bus = mem_data_oe ? mem_data_out : dev_data;
	asc_ctrl asc_ctrl_inst (.sys_clk, .rstn, .req_valid, .req_write, .req_addr, .req_wdata,
		.retention_req, .req_ready, .rsp_valid, .rsp_rdata, .retention_ok, .mem_select_n,
		.mem_write_n, .mem_drive_n, .mem_addr, .mem_data_out, .mem_data_oe, .mem_data_in(bus));
	asc_mem_model asc_mem_model_inst (.select_n(mem_select_n), .write_n(mem_write_n),
		.drive_n(mem_drive_n), .addr(mem_addr), .bus, .dev_data, .dev_oe);
	initial forever #12.5 sys_clk = ~sys_clk;
	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (exp !== got) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task results;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : results
	// Both sides driving the data wire at once
	always @(posedge sys_clk) if (rstn && mem_data_oe && dev_oe) check("fight", 0, 1);
	// One request, held until an edge sees ready high
	task req(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int i;
		{req_write, req_addr, req_wdata, req_valid} = {wr, a, d, 1'b1};
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (req_ready !== 1'b1 && i < 40);
		#2 req_valid = 0;
		if (i == 40) check("ready", 1, 0);
		// Let an edge pass so a following call does not raise valid in this step
		@(posedge sys_clk) #2;
	endtask : req
	// Read and compare the answered byte
	task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		int i;
		req(0, a, '0);
		for (i = 0; i < 20 && rsp_valid !== 1'b1; i++) @(posedge sys_clk) #2;
		check("rsp_valid", 1, rsp_valid);
		check("rdata", exp, rsp_rdata);
	endtask : rd
	task t_idle;
		check("select_n", 1, mem_select_n);
		check("strobe", 1, mem_write_n);
		check("data_oe", 0, mem_data_oe);
		$display("test idle done");
	endtask : t_idle
	// Back-to-back writes at both address ends, slow device
	task t_slow;
		asc_mem_model_inst.lat_ns = 45;
		req(1, '0, 8'h5a);
		req(1, '1, 8'ha5);
		rd('0, 8'h5a);
		rd('1, 8'ha5);
		$display("test slow done");
	endtask : t_slow
	// Prompt device, overwrite then read back
	task t_fast;
		asc_mem_model_inst.lat_ns = 5;
		req(1, 19'h2aaaa, 8'h3c);
		req(1, 19'h2aaaa, 8'hc3);
		rd(19'h2aaaa, 8'hc3);
		$display("test fast done");
	endtask : t_fast
	// Retention blocks a pending request and keeps the device deselected
	task t_ret;
		int i;
		{req_write, req_valid, retention_req} = 3'b011;
		for (i = 0; i < 20 && retention_ok !== 1'b1; i++) @(posedge sys_clk) #2;
		check("retention_ok", 1, retention_ok);
		repeat (4) @(posedge sys_clk) #2;
		check("select_n", 1, mem_select_n);
		{req_valid, retention_req} = 2'b00;
		@(posedge sys_clk) #2;
		check("retention_ok", 0, retention_ok);
		$display("test retention done");
	endtask : t_ret
	initial begin
		repeat (5) @(posedge sys_clk);
		#2 rstn = 1;
		@(posedge sys_clk) #2;
		t_idle();
		t_slow();
		t_fast();
		t_ret();
		results();
	end
endmodule : asc_ctrl_tb_top

/* File: tb/asc_mem_model.sv */
/*
 Behavioural model of the asynchronous byte-wide static memory.
 Pins only, no clock; the bench resolves the shared data wire.
*/
`timescale 1ns/1ps
module asc_mem_model (
	input  wire logic                       select_n,
	input  wire logic                       write_n,
	input  wire logic                       drive_n,
	input  wire logic [asc_pkg::ADDR_W-1:0] addr,
	input  wire logic [asc_pkg::DATA_W-1:0] bus,
	output logic      [asc_pkg::DATA_W-1:0] dev_data,
	output logic                            dev_oe
);
	import asc_pkg::*;
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	realtime           t_a, t_d, t_c;
	int                lat_ns = 45;
	wire               wr_on = !select_n && !write_n;
	// Outputs on only for a read; strobe low or select high floats them
	assign dev_oe = !select_n && !drive_n && write_n;
	// Last movement of each input group
	always @(addr) t_a = $realtime;
	always @(bus) t_d = $realtime;
	always @(select_n, drive_n, write_n, addr) t_c = $realtime;
	// Store at the edge ending the overlap; short setup stores garbage
	always @(negedge wr_on) mem[addr] = ($realtime - t_d >= 25 &&
		$realtime - t_a >= 35) ? bus : ~bus;
	// Data valid once the access time has run; old byte held 10 ns after a change, then toggling
	always #1 dev_data = (dev_oe && $realtime - t_c >= lat_ns && mem.exists(addr))
		? mem[addr] : ($realtime - t_c < 10) ? dev_data : ~dev_data;
	initial dev_data = '0;
endmodule : asc_mem_model
